// [t1_opt_pkg.sv]
/*
 Shared constants and types for the T1 framer option control bank.
 Assumes a 200 MHz system clock and word-aligned Avalon-MM byte addresses.
*/
package t1_opt_pkg;

    // Bus geometry
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [6:0] RX_CTL2_IDX = 7'h2c;
    localparam logic [6:0] TX_CTL1_IDX = 7'h35;
    localparam logic [6:0] TX_CTL2_IDX = 7'h36;
    localparam logic [6:0] ERR_CNT_IDX = 7'h40;
    localparam logic [6:0] STATUS_IDX  = 7'h41;

    // Values after reset, and the error counter limit
    localparam logic [7:0]  CTL_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hffff;

    // receive_control_two fields
    localparam int RX_CODE_SEL_BIT  = 7;
    localparam int RX_ZBTSI_BIT     = 6;
    localparam int RX_SYNC_DW_BIT   = 5;
    localparam int RX_SYNC_MODE_BIT = 4;
    localparam int RX_SYNC_DIR_BIT  = 3;
    localparam int RX_SF_YEL_BIT    = 2;
    localparam int RX_FS_REP_BIT    = 1;
    localparam int RX_MF_CNT_BIT    = 0;

    // transmit_control_one fields
    localparam int TX_CLK_MUX_BIT   = 7;
    localparam int TX_FBIT_PT_BIT   = 6;
    localparam int TX_SIG_INS_BIT   = 4;
    localparam int TX_GLOBAL_BIT7_STUFFING_BIT      = 3;
    localparam int TX_DL_SRC_BIT    = 2;
    localparam int TX_BLUE_BIT      = 1;
    localparam int TX_YELLOW_BIT    = 0;

    // transmit_control_two field used here
    localparam int TX_SF_YEL_BIT    = 1;

    // status register fields
    localparam int ST_CLK_SWAP_BIT  = 2;
    localparam int ST_YELLOW_BIT    = 1;
    localparam int ST_SYNC_IN_BIT   = 0;

    // Channel byte positions, T1 bit 1 is the msb
    localparam int BIT7_POS = 1;
    localparam int BIT2_POS = 6;

    // Substitute idle code
    localparam logic [7:0] IDLE_CODE = 8'h7f;

    // Transmit clock loss timing
    localparam int CLK_NS          = 5;
    localparam int TX_CLK_LOSS_NS  = 2600;
    localparam int TX_CLK_LOSS_CYC = TX_CLK_LOSS_NS / CLK_NS;
    localparam int LOSS_W          = 10;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_t;

endpackage

// [milliwatt_rom.sv]
/*
 Eight-entry table of the digital milliwatt code, registered read data.
 Assumes the caller steps the index once per frame.
*/
`timescale 1ns/1ps
module milliwatt_rom
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] idx,
    output logic      [7:0] data_q
);
    import t1_opt_pkg::*;

    typedef struct packed {
        logic [7:0] data;
    } rom_state_t;

    rom_state_t s_q;
    rom_state_t s_d;

    // Table lookup
    always_comb
    begin
        s_d = s_q;
        unique case (idx)
            3'h0: s_d.data = 8'h1e;
            3'h1: s_d.data = 8'h0b;
            3'h2: s_d.data = 8'h0b;
            3'h3: s_d.data = 8'h1e;
            3'h4: s_d.data = 8'h9e;
            3'h5: s_d.data = 8'h8b;
            3'h6: s_d.data = 8'h8b;
            3'h7: s_d.data = 8'h9e;
        endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign data_q = s_q.data;

endmodule

// [t1_option_ctrl.sv]
/*
 Option register bank steering one T1 framer's receive and transmit paths,
 with an Avalon-MM slave for software access.
 Assumes all framer-side inputs are synchronous to clk.
*/
// Function
// - Code select clear gives idle code 7F as the receive substitute.
// - Receive byte interchange decoding runs only while its enable is set.
// - Double-wide set stretches receive sync pulses in signaling frames.
// - Mode picks frame or multiframe pulses; ignored when pin is input.
// - Direction one makes sync an input; valid only with elastic store.
// - Yellow detect: bit 2 zeros in all channels, or frame 12 S-bit.
// - Fs report enable adds Fs errors to the Ft error report.
// - Counter counts framing errors, or out-of-sync multiframes.
// - Clock mux control switches formatter to receive clock on loss.
// - F-bits made internally, or sampled from transmit data.
// - Signaling inserted from registers unless channel is transparent.
// - Global stuffing forces bit 7 on zero bytes; else per channel.
// - Data link bits from legacy register, or controller/link pin.
`timescale 1ns/1ps
module t1_option_ctrl
(
    input  wire logic                           clk,
    input  wire logic                           rst,
    // Avalon-MM slave
    input  wire logic [t1_opt_pkg::ADDR_W-1:0]  address,
    input  wire logic                           read,
    input  wire logic                           write,
    input  wire logic [3:0]                     byteenable,
    input  wire logic [t1_opt_pkg::DATA_W-1:0]  writedata,
    output logic      [t1_opt_pkg::DATA_W-1:0]  readdata,
    output logic                                waitrequest,
    // Receive side
    input  wire logic                           rx_frame_pulse,
    input  wire logic                           rx_mframe_pulse,
    input  wire logic                           rx_sig_frame,
    input  wire logic                           rx_elastic_store_en,
    input  wire logic                           rx_bit2_all_zero,
    input  wire logic                           rx_frame12_sbit,
    input  wire logic                           rx_ft_error,
    input  wire logic                           rx_fs_error,
    input  wire logic                           rx_mf_out_of_sync,
    output logic      [7:0]                     rx_sub_code,
    output logic                                rx_byte_interchange_en,
    output logic                                rx_sync_pin_o,
    output logic                                rx_sync_pin_oe,
    output logic                                rx_yellow_detect,
    output logic                                rx_frame_error,
    // Transmit side
    input  wire logic                           tx_line_clock,
    input  wire logic                           tx_fbit_internal,
    input  wire logic                           tx_fbit_data,
    input  wire logic                           tx_chan_transparent,
    input  wire logic                           tx_chan_stuff_select,
    input  wire logic [7:0]                     tx_chan_byte,
    input  wire logic                           tx_legacy_link_bit,
    input  wire logic                           tx_ctrl_link_bit,
    input  wire logic                           tx_line_data,
    output logic                                tx_clk_use_rx,
    output logic                                tx_fbit,
    output logic                                tx_sig_insert,
    output logic      [7:0]                     tx_byte_out,
    output logic                                tx_dl_bit,
    output logic                                tx_line_out,
    output logic                                tx_yellow_send
);
    import t1_opt_pkg::*;

    typedef struct packed {
        bus_state_t          bus_st;
        logic                waitreq;
        logic [DATA_W-1:0]   rdata;
        logic [7:0]          rx_ctl;
        logic [7:0]          tx_ctl1;
        logic [7:0]          tx_ctl2;
        logic [15:0]         err_cnt;
        logic [2:0]          mw_idx;
        logic [7:0]          sub_code;
        logic                zbtsi_en;
        logic                sync_out;
        logic                sync_oe;
        logic                sync_hold;
        logic                yel_det;
        logic                frm_err;
        logic [LOSS_W-1:0]   loss_cnt;
        logic                clk_last;
        logic                clk_use_rx;
        logic                fbit;
        logic                sig_ins;
        logic [7:0]          tx_byte;
        logic                dl_bit;
        logic                line_out;
        logic                yel_send;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;
    logic [7:0] mw_code;

    // Register index match on a byte address
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [6:0] idx);
        hit = (a[ADDR_W-1:2] == idx);
    endfunction

    // Saturating increment of the error counter
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == CNT_MAX) ? v : v + 16'h0001;
    endfunction

    // Milliwatt table
    milliwatt_rom u_mw
    (
        .clk    (clk),
        .rst    (rst),
        .idx    (s_q.mw_idx),
        .data_q (mw_code)
    );

    // Next-state logic
    always_comb
    begin
        logic       wr_ok;
        logic       pulse;
        logic       sync_in;
        logic       err_evt;
        logic       cnt_evt;
        logic       cnt_clr;
        logic       lost;
        logic [7:0] byte_v;
        logic [DATA_W-1:0] rd_word;

        wr_ok   = 1'b0;
        pulse   = 1'b0;
        sync_in = 1'b0;
        err_evt = 1'b0;
        cnt_evt = 1'b0;
        cnt_clr = 1'b0;
        lost    = 1'b0;
        byte_v  = 8'h00;
        rd_word = '0;
        s_d     = s_q;

        // Read data mux, unmapped reads return zero
        if (hit(address, RX_CTL2_IDX))
            rd_word = {24'h0, s_q.rx_ctl};
        else if (hit(address, TX_CTL1_IDX))
            rd_word = {24'h0, s_q.tx_ctl1};
        else if (hit(address, TX_CTL2_IDX))
            rd_word = {24'h0, s_q.tx_ctl2};
        else if (hit(address, ERR_CNT_IDX))
            rd_word = {16'h0, s_q.err_cnt};
        else if (hit(address, STATUS_IDX))
            rd_word = {29'h0, s_q.clk_use_rx, s_q.yel_det, ~s_q.sync_oe};

        // Bus handshake, one wait cycle per access
        s_d.waitreq = 1'b1;
        unique case (s_q.bus_st)
            BUS_IDLE:
            begin
                if (read || write)
                begin
                    s_d.bus_st  = BUS_ACK;
                    s_d.waitreq = 1'b0;
                    s_d.rdata   = read ? rd_word : '0;
                end
            end
            BUS_ACK:
            begin
                s_d.bus_st = BUS_IDLE;
                wr_ok      = write && byteenable[0];
            end
        endcase

        // Register writes, low lane only
        if (wr_ok && hit(address, RX_CTL2_IDX))
            s_d.rx_ctl = writedata[7:0];
        if (wr_ok && hit(address, TX_CTL1_IDX))
            s_d.tx_ctl1 = writedata[7:0];
        if (wr_ok && hit(address, TX_CTL2_IDX))
            s_d.tx_ctl2 = writedata[7:0];
        cnt_clr = wr_ok && hit(address, ERR_CNT_IDX);

        // Receive substitute code
        if (rx_frame_pulse)
            s_d.mw_idx = s_q.mw_idx + 3'h1;
        s_d.sub_code = s_q.rx_ctl[RX_CODE_SEL_BIT] ? mw_code
                                                    : IDLE_CODE;
        s_d.zbtsi_en = s_q.rx_ctl[RX_ZBTSI_BIT];

        // Receive sync pin, input only with elastic store on
        sync_in = s_q.rx_ctl[RX_SYNC_DIR_BIT]
                  && rx_elastic_store_en;
        s_d.sync_oe = ~sync_in;
        pulse = s_q.rx_ctl[RX_SYNC_MODE_BIT] ? rx_mframe_pulse
                                              : rx_frame_pulse;
        s_d.sync_hold = pulse && rx_sig_frame
                        && s_q.rx_ctl[RX_SYNC_DW_BIT];
        s_d.sync_out  = sync_in ? 1'b0
                                : (pulse || s_q.sync_hold);

        // Yellow alarm detection
        s_d.yel_det = s_q.rx_ctl[RX_SF_YEL_BIT] ? rx_frame12_sbit
                                                 : rx_bit2_all_zero;

        // Framing bit error report
        err_evt = rx_ft_error
                  || (rx_fs_error && s_q.rx_ctl[RX_FS_REP_BIT]);
        s_d.frm_err = err_evt;

        // Shared counter, a clear with an event loads one
        cnt_evt = s_q.rx_ctl[RX_MF_CNT_BIT] ? rx_mf_out_of_sync
                                             : err_evt;
        if (cnt_clr)
            s_d.err_cnt = cnt_evt ? 16'h0001 : CNT_RESET;
        else if (cnt_evt)
            s_d.err_cnt = sat_inc(s_q.err_cnt);

        // Transmit clock activity watch
        s_d.clk_last = tx_line_clock;
        if (tx_line_clock != s_q.clk_last)
            s_d.loss_cnt = '0;
        else if (s_q.loss_cnt != LOSS_W'(TX_CLK_LOSS_CYC))
            s_d.loss_cnt = s_q.loss_cnt + LOSS_W'(1);
        lost = (s_q.loss_cnt == LOSS_W'(TX_CLK_LOSS_CYC));
        s_d.clk_use_rx = lost && s_q.tx_ctl1[TX_CLK_MUX_BIT];

        // Framing bit source
        s_d.fbit = s_q.tx_ctl1[TX_FBIT_PT_BIT] ? tx_fbit_data
                                                : tx_fbit_internal;

        // Signaling insertion per channel
        s_d.sig_ins = s_q.tx_ctl1[TX_SIG_INS_BIT]
                      && !tx_chan_transparent;

        // Channel byte: yellow bit 2 then bit 7 stuffing
        byte_v = tx_chan_byte;
        if (s_q.tx_ctl1[TX_YELLOW_BIT] && !s_q.tx_ctl2[TX_SF_YEL_BIT])
            byte_v[BIT2_POS] = 1'b0;
        if ((byte_v == 8'h00)
            && (s_q.tx_ctl1[TX_GLOBAL_BIT7_STUFFING_BIT] || tx_chan_stuff_select))
            byte_v[BIT7_POS] = 1'b1;
        s_d.tx_byte = byte_v;

        // Data link source
        s_d.dl_bit = s_q.tx_ctl1[TX_DL_SRC_BIT] ? tx_ctrl_link_bit
                                                 : tx_legacy_link_bit;

        // Line output, blue alarm overrides
        s_d.line_out = s_q.tx_ctl1[TX_BLUE_BIT] ? 1'b1
                                                 : tx_line_data;
        s_d.yel_send = s_q.tx_ctl1[TX_YELLOW_BIT];
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q          <= '0;
            s_q.bus_st   <= BUS_IDLE;
            s_q.waitreq  <= 1'b1;
            s_q.rx_ctl   <= CTL_RESET;
            s_q.tx_ctl1  <= CTL_RESET;
            s_q.tx_ctl2  <= CTL_RESET;
            s_q.err_cnt  <= CNT_RESET;
            s_q.sub_code <= IDLE_CODE;
            s_q.sync_oe  <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign readdata               = s_q.rdata;
    assign waitrequest            = s_q.waitreq;
    assign rx_sub_code            = s_q.sub_code;
    assign rx_byte_interchange_en = s_q.zbtsi_en;
    assign rx_sync_pin_o          = s_q.sync_out;
    assign rx_sync_pin_oe         = s_q.sync_oe;
    assign rx_yellow_detect       = s_q.yel_det;
    assign rx_frame_error         = s_q.frm_err;
    assign tx_clk_use_rx          = s_q.clk_use_rx;
    assign tx_fbit                = s_q.fbit;
    assign tx_sig_insert          = s_q.sig_ins;
    assign tx_byte_out            = s_q.tx_byte;
    assign tx_dl_bit              = s_q.dl_bit;
    assign tx_line_out            = s_q.line_out;
    assign tx_yellow_send         = s_q.yel_send;

endmodule

// [t1_option_ctrl_asserts.sv]
/*
 Checker for the option bank: bus answer and output causes.
 Assumes it is bound to t1_option_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module t1_option_ctrl_chk
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       read,
    input wire logic       write,
    input wire logic       waitrequest,
    input wire logic [7:0] rx_sub_code,
    input wire logic       rx_sync_pin_o,
    input wire logic       rx_sync_pin_oe,
    input wire logic       rx_elastic_store_en,
    input wire logic       rx_yellow_detect,
    input wire logic       rx_bit2_all_zero,
    input wire logic       rx_frame12_sbit,
    input wire logic       rx_frame_error,
    input wire logic       rx_ft_error,
    input wire logic       rx_fs_error,
    input wire logic       tx_fbit,
    input wire logic       tx_fbit_internal,
    input wire logic       tx_fbit_data,
    input wire logic       tx_sig_insert,
    input wire logic       tx_chan_transparent,
    input wire logic [7:0] tx_byte_out,
    input wire logic [7:0] tx_chan_byte,
    input wire logic       tx_line_clock,
    input wire logic       tx_clk_use_rx
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Bus request and answer steps
    sequence req_s; (read || write) && waitrequest; endsequence
    sequence ans_s; !waitrequest; endsequence
    bus_answer_a: assert property (req_s |-> ##[0:2] ans_s)
        else $error("bus request not answered");
    answer_once_a: assert property (ans_s |=> waitrequest)
        else $error("answer held too long");
    // Output causes
    sub_code_a: assert property (rx_sub_code inside
        {8'h7f, 8'h1e, 8'h0b, 8'h9e, 8'h8b}) else $error("bad code");
    sync_input_a: assert property (!rx_sync_pin_oe |->
        !rx_sync_pin_o && $past(rx_elastic_store_en))
        else $error("sync pin input wrongly");
    yellow_cause_a: assert property (rx_yellow_detect |->
        $past(rx_bit2_all_zero || rx_frame12_sbit)) else $error("yellow");
    error_cause_a: assert property (rx_frame_error |->
        $past(rx_ft_error || rx_fs_error)) else $error("frame error");
    fbit_cause_a: assert property (tx_fbit |->
        $past(tx_fbit_internal || tx_fbit_data)) else $error("fbit");
    sig_block_a: assert property (tx_sig_insert |->
        !$past(tx_chan_transparent)) else $error("signaling");
    byte_pass_a: assert property ((tx_byte_out & 8'hbd) ==
        ($past(tx_chan_byte) & 8'hbd)) else $error("byte changed");
    clk_return_a: assert property ((tx_line_clock !=
        $past(tx_line_clock)) |-> ##[1:2] !tx_clk_use_rx)
        else $error("clock not returned");
endmodule

bind t1_option_ctrl t1_option_ctrl_chk u_chk (.clk, .rst, .read, .write,
    .waitrequest, .rx_sub_code, .rx_sync_pin_o, .rx_sync_pin_oe,
    .rx_elastic_store_en, .rx_yellow_detect, .rx_bit2_all_zero,
    .rx_frame12_sbit, .rx_frame_error, .rx_ft_error, .rx_fs_error,
    .tx_fbit, .tx_fbit_internal, .tx_fbit_data, .tx_sig_insert,
    .tx_chan_transparent, .tx_byte_out, .tx_chan_byte, .tx_line_clock,
    .tx_clk_use_rx);

// [tb_top.sv]
/*
 Self-checking bench for the option bank over Avalon-MM.
 Assumes one wait state per access and outputs one edge after inputs.
*/
`timescale 1ns/1ps
module tb_top;
    import t1_opt_pkg::*;
    logic              clk, rst, read, write, waitrequest;
    logic [ADDR_W-1:0] address;
    logic [3:0]        byteenable;
    logic [DATA_W-1:0] writedata, readdata, rdq;
    logic rx_frame_pulse, rx_mframe_pulse, rx_sig_frame, rx_elastic_store_en;
    logic rx_bit2_all_zero, rx_frame12_sbit, rx_ft_error, rx_fs_error;
    logic rx_mf_out_of_sync, rx_byte_interchange_en, rx_sync_pin_o;
    logic rx_sync_pin_oe, rx_yellow_detect, rx_frame_error, tx_line_clock;
    logic tx_fbit_internal, tx_fbit_data, tx_chan_transparent, tx_fbit;
    logic tx_chan_stuff_select, tx_legacy_link_bit, tx_ctrl_link_bit;
    logic tx_line_data, tx_clk_use_rx, tx_sig_insert, tx_dl_bit;
    logic tx_line_out, tx_yellow_send;
    logic [7:0]        rx_sub_code, tx_chan_byte, tx_byte_out;
    int                num_errors, checked;

    t1_option_ctrl u_t1_option_ctrl (.clk, .rst, .address, .read, .write,
        .byteenable, .writedata, .readdata, .waitrequest, .rx_frame_pulse,
        .rx_mframe_pulse, .rx_sig_frame, .rx_elastic_store_en,
        .rx_bit2_all_zero, .rx_frame12_sbit, .rx_ft_error, .rx_fs_error,
        .rx_mf_out_of_sync, .rx_sub_code, .rx_byte_interchange_en,
        .rx_sync_pin_o, .rx_sync_pin_oe, .rx_yellow_detect, .rx_frame_error,
        .tx_line_clock, .tx_fbit_internal, .tx_fbit_data,
        .tx_chan_transparent, .tx_chan_stuff_select, .tx_chan_byte,
        .tx_legacy_link_bit, .tx_ctrl_link_bit, .tx_line_data,
        .tx_clk_use_rx, .tx_fbit, .tx_sig_insert, .tx_byte_out, .tx_dl_bit,
        .tx_line_out, .tx_yellow_send);

    // Clock, 5 ns period
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic final_report;
        $display("Checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Compare one result
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [6:0] idx,
                       input logic [7:0] d);
        int i;
        @(posedge clk);
        address <= {idx, 2'b00};
        write <= wr;
        read <= !wr;
        writedata <= {24'h0, d};
        @(posedge clk);
        for (i = 0; i < 20 && waitrequest !== 1'b0; i++)
            @(posedge clk);
        rdq = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (waitrequest !== 1'b0)
        begin
            num_errors++;
            final_report;
        end
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [6:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        ck(rdq, exp);
    endtask

    // One edge so outputs take up the new inputs
    task automatic st;
        @(posedge clk);
        #1;
    endtask

    // Main sequence
    initial
    begin
        {rst, read, write, address, writedata} = '1;
        {read, write, address, writedata} = '0;
        byteenable = 4'h1;
        {rx_frame_pulse, rx_mframe_pulse, rx_sig_frame} = '0;
        {rx_elastic_store_en, rx_bit2_all_zero, rx_frame12_sbit} = '0;
        {rx_ft_error, rx_fs_error, rx_mf_out_of_sync, tx_line_clock} = '0;
        {tx_fbit_internal, tx_fbit_data, tx_chan_transparent} = '0;
        {tx_chan_stuff_select, tx_legacy_link_bit, tx_ctrl_link_bit} = '0;
        {tx_line_data, tx_chan_byte, num_errors, checked} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        st;
        ck(rx_sub_code, IDLE_CODE);
        ck(rx_sync_pin_oe, 1'b1);
        rd(RX_CTL2_IDX, CTL_RESET);
        rd(TX_CTL1_IDX, CTL_RESET);
        rd(TX_CTL2_IDX, CTL_RESET);
        wr(7'h10, 8'hff);
        rd(7'h10, 32'h0);
        wr(RX_CTL2_IDX, 8'h40);
        rd(RX_CTL2_IDX, 32'h40);
        ck(rx_byte_interchange_en, 1'b1);
        // Framing error report and counter function
        wr(RX_CTL2_IDX, 8'h00);
        @(posedge clk);
        rx_fs_error <= 1'b1;
        st;
        ck(rx_frame_error, 1'b0);
        @(posedge clk);
        {rx_fs_error, rx_ft_error} <= 2'b01;
        st;
        ck(rx_frame_error, 1'b1);
        wr(RX_CTL2_IDX, 8'h03);
        @(posedge clk);
        {rx_fs_error, rx_ft_error} <= 2'b10;
        st;
        ck(rx_frame_error, 1'b1);
        rx_fs_error <= 1'b0;
        wr(ERR_CNT_IDX, 8'h00);
        @(posedge clk);
        {rx_ft_error, rx_mf_out_of_sync} <= 2'b11;
        @(posedge clk);
        {rx_ft_error, rx_mf_out_of_sync} <= 2'b00;
        rd(ERR_CNT_IDX, 32'h1);
        // Yellow detect, both selections
        wr(RX_CTL2_IDX, 8'h00);
        @(posedge clk);
        rx_bit2_all_zero <= 1'b1;
        st;
        ck(rx_yellow_detect, 1'b1);
        @(posedge clk);
        {rx_bit2_all_zero, rx_frame12_sbit} <= 2'b01;
        st;
        ck(rx_yellow_detect, 1'b0);
        wr(RX_CTL2_IDX, 8'h04);
        st;
        ck(rx_yellow_detect, 1'b1);
        // Sync pin as input only with elastic store on
        wr(RX_CTL2_IDX, 8'h18);
        st;
        ck(rx_sync_pin_oe, 1'b1);
        @(posedge clk);
        rx_elastic_store_en <= 1'b1;
        st;
        ck({rx_sync_pin_oe, rx_sync_pin_o}, 2'b00);
        // Milliwatt code, then idle code again
        wr(RX_CTL2_IDX, 8'h80);
        @(posedge clk);
        rx_frame_pulse <= 1'b1;
        @(posedge clk);
        rx_frame_pulse <= 1'b0;
        st;
        ck(rx_sub_code, 8'h1e);
        wr(RX_CTL2_IDX, 8'h00);
        st;
        ck(rx_sub_code, IDLE_CODE);
        // Double-wide sync pulse in a signaling frame
        wr(RX_CTL2_IDX, 8'h20);
        @(posedge clk);
        {rx_frame_pulse, rx_sig_frame} <= 2'b11;
        st;
        ck(rx_sync_pin_o, 1'b1);
        rx_frame_pulse <= 1'b0;
        st;
        ck(rx_sync_pin_o, 1'b1);
        st;
        ck(rx_sync_pin_o, 1'b0);
        // Multiframe mode ignores frame pulses
        wr(RX_CTL2_IDX, 8'h10);
        @(posedge clk);
        rx_mframe_pulse <= 1'b1;
        st;
        ck(rx_sync_pin_o, 1'b1);
        {rx_mframe_pulse, rx_frame_pulse} <= 2'b01;
        st;
        ck(rx_sync_pin_o, 1'b0);
        rx_frame_pulse <= 1'b0;
        // Transmit options all set except clock mux
        wr(TX_CTL1_IDX, 8'h5f);
        rd(TX_CTL1_IDX, 32'h5f);
        @(posedge clk);
        {tx_fbit_data, tx_ctrl_link_bit} <= 2'b11;
        st;
        ck(tx_fbit, 1'b1);
        ck(tx_sig_insert, 1'b1);
        ck(tx_byte_out, 8'h02);
        ck(tx_dl_bit, 1'b1);
        ck(tx_line_out, 1'b1);
        ck(tx_yellow_send, 1'b1);
        @(posedge clk);
        tx_chan_transparent <= 1'b1;
        st;
        ck(tx_sig_insert, 1'b0);
        wr(TX_CTL1_IDX, 8'h00);
        st;
        ck({tx_fbit, tx_sig_insert, tx_dl_bit}, 3'b000);
        ck({tx_line_out, tx_yellow_send}, 2'b00);
        ck(tx_byte_out, 8'h00);
        @(posedge clk);
        tx_chan_stuff_select <= 1'b1;
        st;
        ck(tx_byte_out, 8'h02);
        // Transmit clock loss and return
        ck(tx_clk_use_rx, 1'b0);
        wr(TX_CTL1_IDX, 8'h80);
        repeat (TX_CLK_LOSS_CYC + 4) @(posedge clk);
        #1;
        ck(tx_clk_use_rx, 1'b1);
        @(posedge clk);
        tx_line_clock <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        ck(tx_clk_use_rx, 1'b0);
        final_report;
    end
endmodule
